/* uori_pkg.sv */
// constants and carrier types for the usb otg register interface
package uori_pkg;
   // register byte addresses
   localparam logic [31:0] OTG_FLAGS_ADDR = 32'hbf88_5040;
   localparam logic [31:0] OTG_EN_ADDR = 32'hbf88_5050;
   localparam logic [31:0] OTG_STAT_ADDR = 32'hbf88_5060;
   localparam logic [31:0] OTG_CON_ADDR = 32'hbf88_5070;
   localparam logic [31:0] PWR_ADDR = 32'hbf88_5080;
   localparam logic [31:0] IR_ADDR = 32'hbf88_5200;
   localparam logic [31:0] IE_ADDR = 32'hbf88_5210;
   localparam logic [31:0] EIR_ADDR = 32'hbf88_5220;
   localparam logic [31:0] EIE_ADDR = 32'hbf88_5230;
   localparam logic [31:0] STAT_ADDR = 32'hbf88_5240;
   localparam logic [31:0] CON_ADDR = 32'hbf88_5250;
   localparam logic [31:0] ADDR_ADDR = 32'hbf88_5260;
   localparam logic [31:0] BDT1_ADDR = 32'hbf88_5270;
   localparam logic [31:0] FRML_ADDR = 32'hbf88_5280;
   localparam logic [31:0] FRMH_ADDR = 32'hbf88_5290;
   localparam logic [31:0] TOK_ADDR = 32'hbf88_52a0;
   localparam logic [31:0] SOF_ADDR = 32'hbf88_52b0;
   localparam logic [31:0] BDT2_ADDR = 32'hbf88_52c0;
   localparam logic [31:0] BDT3_ADDR = 32'hbf88_52d0;
   localparam logic [31:0] CFG_ADDR = 32'hbf88_52e0;
   // field positions
   localparam int IR_URST = 0;
   localparam int IR_ERROR_SUMMARY_ENABLE = 1;
   localparam int IR_SOF = 2;
   localparam int IR_TRN = 3;
   localparam int CON_HOST = 3;
   localparam int OF_VBUS = 0;
   localparam int OF_SESSION_ENDED = 2;
   localparam int OF_SESSION_VALID = 3;
   localparam int OF_ACTV = 4;
   localparam int OF_LINE = 5;
   localparam int OF_MSEC = 6;
   localparam int OF_ID = 7;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] OTG_FLAG_MASK = 8'hfd;
   localparam logic [31:0] SLAVE_ERR_DATA = 32'h0000_0000;
   // timing
   localparam int CLK_HZ = 40_000_000;
   localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
   localparam int FS_BIT_HZ = 12_000_000;
   localparam int BYTE_CYC = CLK_HZ / FS_BIT_HZ * 8 + (CLK_HZ % FS_BIT_HZ) * 8 / FS_BIT_HZ;
   localparam int FRAME_US = 1;
   localparam int FRAME_MS_CYC = CLK_HZ / 1000 * FRAME_US;
   localparam int ID_DEB_NS = 1000;
   localparam int ID_DEB_CYC = (ID_DEB_NS + CLK_NS - 1) / CLK_NS;
   localparam int STAT_DEPTH = 16;
   // live comparator and pin levels from the analog side
   typedef struct packed {
      logic id_pin;
      logic line_stable;
      logic session_valid;
      logic session_ended;
      logic bus_voltage_valid;
   } uori_lines_t;
   // token launched towards the serial engine
   typedef struct packed {
      logic [3:0] pid;
      logic [3:0] ep;
      logic [6:0] dev_addr;
   } uori_tok_t;
   // host token scheduler states
   typedef enum logic [2:0] {
      TS_IDLE = 3'b001,
      TS_HELD = 3'b010,
      TS_RUN = 3'b100
   } uori_ts_t;
endpackage : uori_pkg

/* uori_top.sv */
// register file and host frame scheduling of the usb otg module
`timescale 1ns/1ps
module uori_top #(
   parameter int FRAME_CYC = uori_pkg::FRAME_MS_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog and serial engine side
   input wire uori_pkg::uori_lines_t lines,
   input wire logic bus_activity,
   input wire logic [7:0] sie_events,
   input wire logic [7:0] sie_errors,
   input wire logic bus_reset_seen,
   input wire logic sof_received,
   input wire logic [10:0] rx_frame_num,
   input wire logic stat_push,
   input wire logic [7:0] stat_data,
   input wire logic sie_busy,
   input wire logic sie_done,
   // outputs to the module
   output logic usb_irq,
   output logic [7:0] pin_control,
   output logic [7:0] power_control,
   output logic [7:0] module_control,
   output logic [7:0] debug_idle,
   output logic [6:0] dev_addr,
   output logic [31:0] bdt_base,
   output logic tok_start,
   output uori_pkg::uori_tok_t tok_cmd,
   output logic sof_send
);
   import uori_pkg::*;

   localparam int FRAME_BYTES = FRAME_CYC / BYTE_CYC;
   localparam logic [15:0] FRAME_LAST = 16'(FRAME_CYC - 1);
   localparam logic [15:0] FB_LAST = 16'(FRAME_BYTES);
   localparam logic [4:0] BYTE_LAST = 5'(BYTE_CYC - 1);
   localparam logic [5:0] DEB_LAST = 6'(ID_DEB_CYC - 1);

   logic [7:0] oflag_reg, oie_reg, ocon_reg, pwr_reg;
   logic [7:0] ir_reg, ie_reg, eir_reg, eie_reg, con_reg;
   logic [7:0] addr_reg, tok_reg, sof_reg, cfg_reg;
   logic [7:0] bdt1_reg, bdt2_reg, bdt3_reg;
   logic [10:0] frame_reg;
   logic [7:0] fifo_mem [STAT_DEPTH];
   logic [3:0] rd_ptr_reg, wr_ptr_reg;
   logic [4:0] count_reg;
   logic [15:0] fcyc_reg, fbyte_reg;
   logic [4:0] bcyc_reg;
   logic id_stable_reg;
   logic [5:0] deb_reg;
   uori_lines_t lines_d_reg;
   logic win_reg;
   uori_ts_t ts_reg;
   logic [31:0] rdata_next;
   logic rd_err_next;

   ////////////////////////////////////////////////////////////////////
   // apb strobes
   logic wr_en, host_mode, frame_end, win_next, push_ok, pop;
   logic [7:0] wd;
   assign wr_en = psel & penable & pready & pwrite;
   assign wd = pwdata[7:0];
   assign host_mode = con_reg[CON_HOST];

   // zero-wait answer: ready rises in the first access cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & ~penable;
      end
   end

   // read data and error captured during setup
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel & ~penable) begin
         prdata <= rdata_next;
         pslverr <= rd_err_next;
      end
   end

   // read decode
   always_comb begin
      rdata_next = 32'h0000_0000;
      rd_err_next = 1'b0;
      if (paddr == OTG_FLAGS_ADDR) begin
         rdata_next[7:0] = oflag_reg;
      end else if (paddr == OTG_EN_ADDR) begin
         rdata_next[7:0] = oie_reg;
      end else if (paddr == OTG_STAT_ADDR) begin
         rdata_next[7:0] = {id_stable_reg, 1'b0, lines.line_stable, 1'b0,
                            lines.session_valid, lines.session_ended, 1'b0,
                            lines.bus_voltage_valid};
      end else if (paddr == OTG_CON_ADDR) begin
         rdata_next[7:0] = ocon_reg;
      end else if (paddr == PWR_ADDR) begin
         rdata_next[7:0] = pwr_reg;
      end else if (paddr == IR_ADDR) begin
         rdata_next[7:0] = ir_reg;
      end else if (paddr == IE_ADDR) begin
         rdata_next[7:0] = ie_reg;
      end else if (paddr == EIR_ADDR) begin
         rdata_next[7:0] = eir_reg;
      end else if (paddr == EIE_ADDR) begin
         rdata_next[7:0] = eie_reg;
      end else if (paddr == STAT_ADDR) begin
         rdata_next[7:0] = fifo_mem[rd_ptr_reg];
      end else if (paddr == CON_ADDR) begin
         rdata_next[7:0] = con_reg;
      end else if (paddr == ADDR_ADDR) begin
         rdata_next[7:0] = addr_reg;
      end else if (paddr == BDT1_ADDR) begin
         rdata_next[7:0] = {bdt1_reg[7:1], 1'b0};
      end else if (paddr == BDT2_ADDR) begin
         rdata_next[7:0] = bdt2_reg;
      end else if (paddr == BDT3_ADDR) begin
         rdata_next[7:0] = bdt3_reg;
      end else if (paddr == FRML_ADDR) begin
         rdata_next[7:0] = frame_reg[7:0];
      end else if (paddr == FRMH_ADDR) begin
         rdata_next[7:0] = {5'b00000, frame_reg[10:8]};
      end else if (paddr == TOK_ADDR) begin
         rdata_next[7:0] = tok_reg;
      end else if (paddr == SOF_ADDR) begin
         rdata_next[7:0] = sof_reg;
      end else if (paddr == CFG_ADDR) begin
         rdata_next[7:0] = cfg_reg;
      end else begin
         rdata_next = SLAVE_ERR_DATA;
         rd_err_next = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // plain read/write control registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         oie_reg <= REG_RESET;
         ocon_reg <= REG_RESET;
         pwr_reg <= REG_RESET;
         ie_reg <= REG_RESET;
         eie_reg <= REG_RESET;
         con_reg <= REG_RESET;
         sof_reg <= REG_RESET;
         cfg_reg <= REG_RESET; // expected set before module enable
      end else if (wr_en) begin
         if (paddr == OTG_EN_ADDR) oie_reg <= wd;
         if (paddr == OTG_CON_ADDR) ocon_reg <= wd;
         if (paddr == PWR_ADDR) pwr_reg <= wd;
         if (paddr == IE_ADDR) ie_reg <= wd;
         if (paddr == EIE_ADDR) eie_reg <= wd;
         if (paddr == CON_ADDR) con_reg <= wd;
         if (paddr == SOF_ADDR) sof_reg <= wd;
         if (paddr == CFG_ADDR) cfg_reg <= wd;
      end
   end

   // base pointer, usable at any time, low nine bits forced to zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bdt1_reg <= REG_RESET;
         bdt2_reg <= REG_RESET;
         bdt3_reg <= REG_RESET;
      end else if (wr_en) begin
         if (paddr == BDT1_ADDR) bdt1_reg <= wd;
         if (paddr == BDT2_ADDR) bdt2_reg <= wd;
         if (paddr == BDT3_ADDR) bdt3_reg <= wd;
      end
   end

   // bus address: only software or a device-mode bus reset touch it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         addr_reg <= REG_RESET;
      end else if (bus_reset_seen & ~host_mode) begin
         addr_reg <= REG_RESET; // reset wins over a racing write
      end else if (wr_en & (paddr == ADDR_ADDR)) begin
         addr_reg <= wd;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // id pin debounce: new level must hold for the whole window
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         id_stable_reg <= 1'b0;
         deb_reg <= 6'd0;
      end else if (lines.id_pin == id_stable_reg) begin
         deb_reg <= 6'd0;
      end else if (deb_reg == DEB_LAST) begin
         id_stable_reg <= lines.id_pin;
         deb_reg <= 6'd0;
      end else begin
         deb_reg <= deb_reg + 6'd1;
      end
   end

   // previous levels for change detection
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lines_d_reg <= '0;
      end else begin
         lines_d_reg <= lines;
      end
   end

   // otg event flags, set beats clear
   logic [7:0] oset;
   always_comb begin
      oset = 8'h00;
      oset[OF_VBUS] = lines.bus_voltage_valid ^ lines_d_reg.bus_voltage_valid;
      oset[OF_SESSION_ENDED] = lines.session_ended ^ lines_d_reg.session_ended;
      oset[OF_SESSION_VALID] = lines.session_valid ^ lines_d_reg.session_valid;
      oset[OF_ACTV] = bus_activity;
      oset[OF_LINE] = lines.line_stable ^ lines_d_reg.line_stable;
      oset[OF_MSEC] = frame_end;
      oset[OF_ID] = deb_reg == DEB_LAST && lines.id_pin != id_stable_reg;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         oflag_reg <= REG_RESET;
      end else if (wr_en & (paddr == OTG_FLAGS_ADDR)) begin
         oflag_reg <= (oflag_reg & ~wd | oset) & OTG_FLAG_MASK;
      end else begin
         oflag_reg <= (oflag_reg | oset) & OTG_FLAG_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pending interrupts and errors
   logic [7:0] iset, iclr, eclr;
   logic frame_irq;
   assign pop = wr_en & (paddr == IR_ADDR) & wd[IR_TRN] & (count_reg != 5'd0);
   assign frame_irq = host_mode ? (win_next & ~win_reg) : sof_received;
   assign iclr = (wr_en & (paddr == IR_ADDR)) ? wd : 8'h00;
   assign eclr = (wr_en & (paddr == EIR_ADDR)) ? wd : 8'h00;

   always_comb begin
      iset = sie_events;
      iset[IR_URST] = sie_events[IR_URST] | bus_reset_seen;
      iset[IR_ERROR_SUMMARY_ENABLE] = |sie_errors;
      iset[IR_SOF] = frame_irq;
      iset[IR_TRN] = push_ok | (pop & (count_reg > 5'd1));
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ir_reg <= REG_RESET;
         eir_reg <= REG_RESET;
      end else begin
         ir_reg <= ir_reg & ~iclr | iset;
         eir_reg <= eir_reg & ~eclr | sie_errors;
      end
   end

   // one interrupt line; enables gate only, nothing else reads them
   logic [7:0] ie_plain;
   always_comb begin
      ie_plain = ie_reg;
      ie_plain[IR_ERROR_SUMMARY_ENABLE] = 1'b0;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         usb_irq <= 1'b0;
      end else begin
         usb_irq <= |(ir_reg & ie_plain)
                  | (ie_reg[IR_ERROR_SUMMARY_ENABLE] & |(eir_reg & eie_reg))
                  | |(oflag_reg & oie_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // transaction status fifo; a push into a full fifo is dropped
   assign push_ok = stat_push & (count_reg != 5'(STAT_DEPTH));

   always_ff @(posedge clk) begin
      if (push_ok) fifo_mem[wr_ptr_reg] <= stat_data;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_ptr_reg <= 4'd0;
         wr_ptr_reg <= 4'd0;
         count_reg <= 5'd0;
      end else begin
         if (push_ok) wr_ptr_reg <= wr_ptr_reg + 4'd1;
         if (pop) rd_ptr_reg <= rd_ptr_reg + 4'd1;
         count_reg <= count_reg + 5'(push_ok) - 5'(pop);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // frame timer in clock cycles, with a bus byte count alongside; wraps every millisecond
   assign frame_end = fcyc_reg == FRAME_LAST;
   assign win_next = host_mode & (FB_LAST - fbyte_reg <= {8'h00, sof_reg});

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fcyc_reg <= 16'd0;
         bcyc_reg <= 5'd0;
         fbyte_reg <= 16'd0;
         win_reg <= 1'b0;
      end else begin
         win_reg <= win_next;
         if (frame_end) begin
            fcyc_reg <= 16'd0;
            bcyc_reg <= 5'd0;
            fbyte_reg <= 16'd0;
         end else begin
            fcyc_reg <= fcyc_reg + 16'd1;
            bcyc_reg <= (bcyc_reg == BYTE_LAST) ? 5'd0 : bcyc_reg + 5'd1;
            if (bcyc_reg == BYTE_LAST) fbyte_reg <= fbyte_reg + 16'd1;
         end
      end
   end

   // frame number: counted in host mode, taken from received sof otherwise
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         frame_reg <= 11'd0;
         sof_send <= 1'b0;
      end else begin
         sof_send <= host_mode & frame_end;
         if (host_mode & frame_end) begin
            frame_reg <= frame_reg + 11'd1;
         end else if (~host_mode & sof_received) begin
            frame_reg <= rx_frame_num;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // host token scheduler; a write lands in held, the window delays launch
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tok_reg <= REG_RESET;
         ts_reg <= TS_IDLE;
         tok_start <= 1'b0;
         tok_cmd <= '0;
      end else begin
         tok_start <= 1'b0;
         if (wr_en & (paddr == TOK_ADDR)) tok_reg <= wd;
         case (ts_reg)
            TS_IDLE: begin
               if (wr_en & (paddr == TOK_ADDR) & host_mode) ts_reg <= TS_HELD;
            end
            TS_HELD: begin
               if (~win_reg & ~sie_busy) begin
                  tok_start <= 1'b1;
                  tok_cmd <= {tok_reg[7:4], tok_reg[3:0], addr_reg[6:0]};
                  ts_reg <= TS_RUN;
               end
            end
            TS_RUN: begin
               if (sie_done) ts_reg <= TS_IDLE; // runs on through the window
            end
            default: ts_reg <= TS_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registered copies of control fields for the module
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_control <= REG_RESET;
         power_control <= REG_RESET;
         module_control <= REG_RESET;
         debug_idle <= REG_RESET;
         dev_addr <= 7'd0;
         bdt_base <= 32'h0000_0000;
      end else begin
         pin_control <= ocon_reg;
         power_control <= pwr_reg;
         module_control <= con_reg;
         debug_idle <= cfg_reg;
         dev_addr <= addr_reg[6:0];
         bdt_base <= {bdt3_reg, bdt2_reg, bdt1_reg[7:1], 9'h000};
      end
   end
endmodule : uori_top

/* uori_sie_model.sv */
// serial engine stand-in that answers launched host tokens
`timescale 1ns/1ps
module uori_sie_model #(
   parameter int BUSY_CYC = 6
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // token handshake
   input wire logic tok_start,
   output logic sie_busy,
   output logic sie_done
);
   import uori_pkg::*;
   int cnt;
   // busy from launch to packet end, then one done pulse
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sie_busy <= 1'b0;
         sie_done <= 1'b0;
         cnt <= 0;
      end else begin
         sie_done <= sie_busy && cnt == 1;
         if (tok_start) begin
            sie_busy <= 1'b1;
            cnt <= BUSY_CYC;
         end else if (cnt > 0) begin
            cnt <= cnt - 1;
            sie_busy <= cnt > 1;
         end
      end
   end
endmodule : uori_sie_model

/* uori_chk.sv */
// port-level assertions of the usb otg register interface
`timescale 1ns/1ps
module uori_chk
   import uori_pkg::*;
#(
   parameter int FRAME_CYC = 520
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // module side
   input wire logic bus_reset_seen,
   input wire logic sie_busy,
   input wire logic [7:0] module_control,
   input wire logic [6:0] dev_addr,
   input wire logic [31:0] bdt_base,
   input wire logic tok_start,
   input wire uori_pkg::uori_tok_t tok_cmd,
   input wire logic sof_send
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // completed access, the only moment a write lands
   wire logic acc = psel && penable && pready;
   apb_ready_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   off_page_a: assert property (pready && paddr[31:12] != 20'hbf886 - 20'h1 |-> pslverr
      && prdata == 32'h0000_0000) else $error("unmapped access not refused");
   addr_load_a: assert property (acc && pwrite && paddr == ADDR_ADDR && !bus_reset_seen
      |=> ##1 dev_addr == $past(pwdata[6:0], 2)) else $error("address not loaded");
   addr_clear_a: assert property (bus_reset_seen && !module_control[CON_HOST]
      |=> ##1 dev_addr == 7'h00) else $error("address kept over bus reset");
   base_align_a: assert property (bdt_base[8:0] == 9'h000)
      else $error("descriptor base not aligned");
   token_addr_a: assert property (tok_start |-> tok_cmd.dev_addr == dev_addr)
      else $error("token address differs");
   token_idle_a: assert property (tok_start |-> !$past(sie_busy))
      else $error("token launched while engine busy");
   token_pulse_a: assert property (tok_start |=> !tok_start [*3])
      else $error("token start not a single pulse");
   frame_pulse_a: assert property (sof_send |=> !sof_send [*8])
      else $error("frame start not a single pulse");
endmodule : uori_chk
bind uori_top uori_chk #(.FRAME_CYC(FRAME_CYC)) u_chk (.clk, .rst_b, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_reset_seen, .sie_busy,
   .module_control, .dev_addr, .bdt_base, .tok_start, .tok_cmd, .sof_send);

/* uori_bench.sv */
// self-checking bench of the usb otg register interface
`timescale 1ns/1ps
module uori_bench;
   import uori_pkg::*;
   localparam int FC = 520;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, bdt_base, rd;
   logic pready, pslverr, usb_irq, tok_start, sof_send, sie_busy, sie_done, err, sof_seen;
   logic [7:0] pin_control, power_control, module_control, debug_idle;
   logic [6:0] dev_addr;
   uori_tok_t tok_cmd;
   uori_lines_t lines = '0;
   logic bus_activity = 1'b0;
   logic bus_reset_seen = 1'b0;
   logic sof_received = 1'b0;
   logic stat_push = 1'b0;
   logic [7:0] sie_events = '0;
   logic [7:0] sie_errors = '0;
   logic [7:0] stat_data = '0;
   logic [10:0] rx_frame_num = '0;
   int mismatches = 0;
   int n_compared = 0;
   localparam logic [31:0] RA [6] = '{OTG_FLAGS_ADDR, IR_ADDR, EIR_ADDR, ADDR_ADDR,
      BDT1_ADDR, TOK_ADDR};
   // free-running clock; small frame keeps the run short
   always #12.5 clk = ~clk;
   uori_top #(.FRAME_CYC(FC)) u_dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .lines, .bus_activity, .sie_events, .sie_errors,
      .bus_reset_seen, .sof_received, .rx_frame_num, .stat_push, .stat_data, .sie_busy,
      .sie_done, .usb_irq, .pin_control, .power_control, .module_control, .debug_idle,
      .dev_addr, .bdt_base, .tok_start, .tok_cmd, .sof_send);
   uori_sie_model #(.BUSY_CYC(6)) u_sie (.clk(clk), .rst_b(rst_b), .tok_start(tok_start),
      .sie_busy(sie_busy), .sie_done(sie_done));
   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // no local limit: only the watchdog may end a stuck wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] e);
      apb(1'b0, a, '0);
      chk(nm, e, rd);
   endtask : rc
   // irq is registered one cycle after the flags
   task automatic ci(input logic e);
      repeat (2) @(posedge clk);
      chk("irq", e, usb_irq);
   endtask : ci
   // bounded wait for a launch, noting any frame start first
   task automatic wt;
      int n;
      n = 0;
      sof_seen = 1'b0;
      while (tok_start !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
         if (sof_send === 1'b1) sof_seen = 1'b1;
      end
   endtask : wt
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////
   // watchdog far beyond the expected run of about five hundred cycles
   initial begin
      #1_000_000;
      mismatches++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      int n;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      foreach (RA[i]) rc("reset", RA[i], '0);
      rc("unmapped", 32'hbf88_6000, '0);
      chk("slverr", 1'b1, err);
      apb(1'b1, ADDR_ADDR, 32'h5a);
      rc("addr", ADDR_ADDR, 32'h5a);
      @(posedge clk);
      bus_reset_seen <= 1'b1;
      @(posedge clk);
      bus_reset_seen <= 1'b0;
      rc("addr", ADDR_ADDR, '0);
      apb(1'b1, IR_ADDR, '0);
      rc("ir", IR_ADDR, 32'h1);
      apb(1'b1, IR_ADDR, 32'h1);
      rc("ir", IR_ADDR, '0);
      // error path and its summary gating
      @(posedge clk);
      sie_errors <= 8'h81;
      @(posedge clk);
      sie_errors <= 8'h00;
      rc("eir", EIR_ADDR, 32'h81);
      rc("ir", IR_ADDR, 32'h2);
      apb(1'b1, EIR_ADDR, 32'h01);
      rc("eir", EIR_ADDR, 32'h80);
      apb(1'b1, EIE_ADDR, 32'h80);
      ci(1'b0);
      apb(1'b1, IE_ADDR, 32'h02);
      ci(1'b1);
      apb(1'b1, IE_ADDR, '0);
      apb(1'b1, EIR_ADDR, 32'hff);
      apb(1'b1, IR_ADDR, 32'hff);
      @(posedge clk);
      sie_events <= 8'h80;
      @(posedge clk);
      sie_events <= 8'h00;
      ci(1'b0);
      apb(1'b1, IE_ADDR, 32'h80);
      ci(1'b1);
      apb(1'b1, IR_ADDR, 32'h80);
      ci(1'b0);
      // 17 pushes into a 16-deep fifo, then drain
      for (int i = 0; i < 17; i++) begin
         @(posedge clk);
         stat_push <= 1'b1;
         stat_data <= i[7:0];
      end
      @(posedge clk);
      stat_push <= 1'b0;
      apb(1'b1, STAT_ADDR, 32'hff);
      for (int i = 0; i < 16; i++) begin
         rc("stat", STAT_ADDR, i);
         apb(1'b1, IR_ADDR, 32'h8);
      end
      rc("ir", IR_ADDR, '0);
      // received frame start in device mode
      @(posedge clk);
      rx_frame_num <= 11'h5a3;
      sof_received <= 1'b1;
      @(posedge clk);
      sof_received <= 1'b0;
      apb(1'b1, FRML_ADDR, 32'hff);
      rc("frml", FRML_ADDR, 32'ha3);
      rc("frmh", FRMH_ADDR, 32'h05);
      rc("ir", IR_ADDR, 32'h4);
      apb(1'b1, IR_ADDR, 32'h4);
      apb(1'b1, OTG_CON_ADDR, 32'h3c);
      apb(1'b1, CFG_ADDR, 32'h41);
      apb(1'b1, PWR_ADDR, 32'h01);
      apb(1'b1, BDT1_ADDR, 32'hff);
      apb(1'b1, BDT2_ADDR, 32'h12);
      apb(1'b1, BDT3_ADDR, 32'h34);
      // registered copies trail the landing edge by one clock
      repeat (2) @(posedge clk);
      chk("bdt", 32'h3412_fe00, bdt_base);
      chk("pinctl", 32'h3c, pin_control);
      chk("dbgidle", 32'h41, debug_idle);
      chk("pwrctl", 32'h01, power_control);
      rc("bdt2", BDT2_ADDR, 32'h12);
      // comparator and pin changes
      @(posedge clk);
      lines <= 5'b10101;
      bus_activity <= 1'b1;
      @(posedge clk);
      bus_activity <= 1'b0;
      repeat (50) @(posedge clk);
      rc("otgstat", OTG_STAT_ADDR, 32'h89);
      apb(1'b1, OTG_FLAGS_ADDR, '0);
      apb(1'b0, OTG_FLAGS_ADDR, '0);
      chk("otgflags", 32'h99, rd & 32'hbd);
      apb(1'b1, OTG_EN_ADDR, 32'h1);
      ci(1'b1);
      apb(1'b1, OTG_EN_ADDR, '0);
      apb(1'b1, OTG_FLAGS_ADDR, 32'hff);
      ci(1'b0);
      // host tokens, plain and inside the frame-end window
      apb(1'b1, CON_ADDR, 32'h08);
      apb(1'b1, ADDR_ADDR, 32'h15);
      apb(1'b1, SOF_ADDR, 32'h5);
      apb(1'b1, TOK_ADDR, 32'hd3);
      wt();
      chk("tok", {4'hd, 4'h3, 7'h15}, tok_cmd);
      chk("modctl", 32'h08, module_control);
      apb(1'b1, IR_ADDR, 32'h4);
      n = 0;
      do begin
         apb(1'b0, IR_ADDR, '0);
         n++;
      end while (rd[IR_SOF] !== 1'b1 && n < 400);
      chk("sof", 32'h4, rd & 32'h4);
      apb(1'b1, TOK_ADDR, 32'h95);
      wt();
      chk("held", 1'b1, sof_seen);
      chk("tok", {4'h9, 4'h5, 7'h15}, tok_cmd);
      tally_and_finish();
   end
endmodule : uori_bench
